// ===== lscb_pkg.sv
// Package: shared constants and carrier types of the load/store cache bypass path
package lscb_pkg;

  // ***************
  // Widths and address fields
  // ***************
  localparam int ADDR_W        = 32;
  localparam int DATA_W        = 32;
  localparam int BYPASS_BIT    = 31;
  localparam int PAGE_OFF_HI   = 11;
  localparam int COLOR_LO      = 12;
  localparam int LINE_OFF_W    = 4;
  localparam int INDEX_W       = 12;
  localparam int PFN_W         = 20;
  localparam int IMM_W         = 16;
  localparam int LINES         = 4096;
  localparam int BYTE_W        = 8;
  localparam int HALF_W        = 16;
  localparam logic [31:0] BYPASS_SPACE_MASK = 32'h7FFFFFFF;

  // ***************
  // Operation encodings
  // ***************
  typedef enum logic [1:0] {
    LSCB_SZ_BYTE = 2'h0,
    LSCB_SZ_HALF = 2'h1,
    LSCB_SZ_WORD = 2'h2
  } lscb_size_type;

  typedef struct packed {
    logic                  valid;
    logic                  isStore;
    logic                  ioForm;
    logic                  signedLoad;
    logic                  cacheInit;
    logic                  cacheFlush;
    lscb_size_type         size;
    logic [ADDR_W-1:0]     base;
    logic [IMM_W-1:0]      imm;
    logic [DATA_W-1:0]     storeData;
  } lscb_req_type;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [ADDR_W-1:0]     addr;
    logic [3:0]            byteEn;
    logic [DATA_W-1:0]     wdata;
  } lscb_bus_type;

  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic                  bypass;
  } lscb_route_type;

endpackage

// ===== lscb_route.sv
// Route decision: effective address and cache bypass selection
`timescale 1ns/1ps
`default_nettype none
module lscb_route (
  input  wire  logic                      mmuPresent,
  input  wire  logic                      pageCacheable,
  input  wire  lscb_pkg::lscb_req_type    req,
  output logic [lscb_pkg::ADDR_W-1:0]     effAddr,
  output lscb_pkg::lscb_route_type        route
);
  import lscb_pkg::*;

  always_comb begin
    effAddr = req.base + {{(ADDR_W-IMM_W){req.imm[IMM_W-1]}}, req.imm};
    if (mmuPresent) begin
      route.addr   = effAddr;
      route.bypass = !pageCacheable;
    end else begin
      route.addr   = effAddr & BYPASS_SPACE_MASK;
      route.bypass = effAddr[BYPASS_BIT];
    end
    if (req.ioForm) begin
      route.bypass = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== lscb_extend.sv
// Load data lane select and sign or zero extension
`timescale 1ns/1ps
`default_nettype none
module lscb_extend (
  input  wire  logic [lscb_pkg::DATA_W-1:0] rawData,
  input  wire  logic [1:0]                  byteOff,
  input  wire  lscb_pkg::lscb_size_type     size,
  input  wire  logic                        signedLoad,
  output logic [lscb_pkg::DATA_W-1:0]       loadData
);
  import lscb_pkg::*;

  logic [DATA_W-1:0] shifted;

  always_comb begin
    shifted = rawData >> {byteOff, 3'h0};
    case (size)
      LSCB_SZ_BYTE: begin
        loadData = signedLoad ? {{(DATA_W-BYTE_W){shifted[BYTE_W-1]}}, shifted[BYTE_W-1:0]}
                              : {{(DATA_W-BYTE_W){1'b0}}, shifted[BYTE_W-1:0]};
      end
      LSCB_SZ_HALF: begin
        loadData = signedLoad ? {{(DATA_W-HALF_W){shifted[HALF_W-1]}}, shifted[HALF_W-1:0]}
                              : {{(DATA_W-HALF_W){1'b0}}, shifted[HALF_W-1:0]};
      end
      default: begin
        loadData = rawData;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== lscb_path.sv
// Load/store data path with direct-mapped VIPT data cache and cache bypass
//
// Functional notes
// - No MMU: data address bit 31 selects cache bypass.
// - Bit-31 bypass limits the addressable space to 2 GB.
// - With MMU: page attributes give cacheability; bit 31 is ordinary.
// - Uncached word loads and stores move 32-bit words, no cache or buffer.
// - Uncached bus cycles occur in program order, never merged or dropped.
// - Cached word access address is register plus signed immediate.
// - Cached loads may be served by the cache and skip the bus; stores always go to the bus.
// - Signed narrow loads sign-extend, unsigned ones zero-extend, to 32 bits.
// - Byte and half stores write only that width, possibly through cache.
// - Uncached narrow forms do the same narrow transfers without caching.
// - Cache initialise and flush operations are provided.
// - Without a cache every cache management operation is a no-op.
// - Line selected by virtual bits, tag compared on physical bits.
// - 4 KB pages: bits 11:0 untranslated; small caches index by them.
// - Tag holds the whole physical frame number.
// - Little-endian: more significant bytes at higher addresses.
// - 32-bit data bus with byte, half-word and word writes; reads move whole words.
`timescale 1ns/1ps
`default_nettype none
module lscb_path #(
  parameter bit HAS_CACHE = 1'b1
) (
  input  wire  logic                        clock,
  input  wire  logic                        resetn,
  input  wire  logic                        mmuPresent,
  input  wire  lscb_pkg::lscb_req_type      req,
  input  wire  logic [lscb_pkg::PFN_W-1:0]  physPfn,
  input  wire  logic                        pageCacheable,
  output logic                              reqReady,
  output logic                              respValid,
  output logic [lscb_pkg::DATA_W-1:0]       respData,
  output lscb_pkg::lscb_bus_type            busReq,
  input  wire  logic                        busWaitreq,
  input  wire  logic                        busRvalid,
  input  wire  logic [lscb_pkg::DATA_W-1:0] busRdata
);
  import lscb_pkg::*;

  // ***************
  // Route and address
  // ***************
  logic [ADDR_W-1:0] effAddr;
  lscb_route_type    route;

  lscb_route routeUnit (
    .mmuPresent   (mmuPresent),
    .pageCacheable(pageCacheable),
    .req          (req),
    .effAddr      (effAddr),
    .route        (route)
  );

  // ***************
  // State
  // ***************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BUS  = 4'h2,
    ST_WAIT = 4'h4,
    ST_INIT = 4'h8
  } lscb_state_type;

  lscb_state_type      state, next_state;
  lscb_req_type        held, next_held;
  lscb_route_type      heldRoute, next_heldRoute;
  logic [PFN_W-1:0]    heldPfn, next_heldPfn;
  lscb_bus_type        next_busReq;
  logic                next_reqReady;
  logic                next_respValid;
  logic [DATA_W-1:0]   next_respData;
  logic [INDEX_W-1:0]  initIdx, next_initIdx;

  // Cache storage: data, tag, valid per line
  logic [DATA_W-1:0]   cacheData [LINES];
  logic [PFN_W-1:0]    cacheTag  [LINES];
  // Word within the indexed span, kept so neighbouring words never alias
  logic [LINE_OFF_W-3:0] cacheWord [LINES];
  logic [LINE_OFF_W-3:0] wrWord;
  logic [LINES-1:0]    lineValid, next_lineValid;
  logic                wrLine;
  logic [INDEX_W-1:0]  wrIdx;
  logic [DATA_W-1:0]   wrData;
  logic [PFN_W-1:0]    wrTag;

  // ***************
  // Lookup
  // ***************
  logic [INDEX_W-1:0]  vIdx;
  logic [PFN_W-1:0]    lookupPfn;
  logic [LINE_OFF_W-3:0] lookupWord;
  logic                hit;
  logic [3:0]          laneEn;
  logic [DATA_W-1:0]   laneData;
  logic [DATA_W-1:0]   mergedLine;
  logic [DATA_W-1:0]   loadExt;
  logic [DATA_W-1:0]   busExt;
  logic                cachedPath;

  always_comb begin
    vIdx = route.addr[LINE_OFF_W+INDEX_W-1:LINE_OFF_W];
    // Without translation the frame number is the upper address itself
    lookupPfn  = mmuPresent ? physPfn : route.addr[ADDR_W-1:COLOR_LO];
    lookupWord = route.addr[LINE_OFF_W-1:2];
    hit  = lineValid[vIdx] && (cacheTag[vIdx] == lookupPfn)
           && (cacheWord[vIdx] == lookupWord);
    case (req.size)
      LSCB_SZ_BYTE: laneEn = 4'h1 << route.addr[1:0];
      LSCB_SZ_HALF: laneEn = 4'h3 << {route.addr[1], 1'b0};
      default:      laneEn = 4'hF;
    endcase
    laneData = req.storeData << {route.addr[1:0], 3'h0};
    for (int b = 0; b < 4; b++) begin
      mergedLine[b*8 +: 8] = laneEn[b] ? laneData[b*8 +: 8] : cacheData[vIdx][b*8 +: 8];
    end
    cachedPath = HAS_CACHE && !route.bypass;
  end

  lscb_extend hitExtend (
    .rawData   (cacheData[vIdx]),
    .byteOff   (route.addr[1:0]),
    .size      (req.size),
    .signedLoad(req.signedLoad),
    .loadData  (loadExt)
  );

  lscb_extend busExtend (
    .rawData   (busRdata),
    .byteOff   (heldRoute.addr[1:0]),
    .size      (held.size),
    .signedLoad(held.signedLoad),
    .loadData  (busExt)
  );

  // ***************
  // Control
  // ***************
  always_comb begin
    next_state     = state;
    next_held      = held;
    next_heldRoute = heldRoute;
    next_heldPfn   = heldPfn;
    next_busReq    = busReq;
    next_reqReady  = reqReady;
    next_respValid = 1'b0;
    next_respData  = respData;
    next_initIdx   = initIdx;
    next_lineValid = lineValid;
    wrLine         = 1'b0;
    wrIdx          = vIdx;
    wrData         = mergedLine;
    wrTag          = lookupPfn;
    wrWord         = lookupWord;
    case (state)
      ST_IDLE: begin
        if (req.valid && reqReady) begin
          next_held      = req;
          next_heldRoute = route;
          next_heldPfn   = lookupPfn;
          if (req.cacheInit || req.cacheFlush) begin
            if (HAS_CACHE) begin
              next_initIdx  = '0;
              next_reqReady = 1'b0;
              next_state    = ST_INIT;
            end else begin
              next_respValid = 1'b1;
            end
          end else if (cachedPath && !req.isStore && hit) begin
            next_respValid = 1'b1;
            next_respData  = loadExt;
          end else begin
            if (cachedPath && req.isStore && hit) begin
              wrLine = 1'b1;
            end
            // Uncached accesses, load misses and all stores go out one at a time, in order
            next_busReq.valid  = 1'b1;
            next_busReq.write  = req.isStore;
            next_busReq.addr   = {route.addr[ADDR_W-1:2], 2'h0};
            next_busReq.byteEn = req.isStore ? laneEn : 4'hF;
            next_busReq.wdata  = laneData;
            next_reqReady      = 1'b0;
            next_state         = ST_BUS;
          end
        end
      end
      ST_BUS: begin
        if (!busWaitreq) begin
          next_busReq.valid = 1'b0;
          if (busReq.write) begin
            next_respValid = 1'b1;
            next_reqReady  = 1'b1;
            next_state     = ST_IDLE;
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (busRvalid) begin
          next_respValid = 1'b1;
          next_respData  = busExt;
          next_reqReady  = 1'b1;
          next_state     = ST_IDLE;
          if (HAS_CACHE && !heldRoute.bypass) begin
            wrLine = 1'b1;
            wrIdx  = heldRoute.addr[LINE_OFF_W+INDEX_W-1:LINE_OFF_W];
            wrData = busRdata;
            wrTag  = heldPfn;
            wrWord = heldRoute.addr[LINE_OFF_W-1:2];
            next_lineValid[wrIdx] = 1'b1;
          end
        end
      end
      ST_INIT: begin
        next_lineValid[initIdx] = 1'b0;
        next_initIdx = initIdx + 1'b1;
        if (initIdx == INDEX_W'(LINES-1)) begin
          next_respValid = 1'b1;
          next_reqReady  = 1'b1;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state    = ST_IDLE;
        next_reqReady = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      held      <= '0;
      heldRoute <= '0;
      heldPfn   <= '0;
      busReq    <= '0;
      reqReady  <= 1'b1;
      respValid <= 1'b0;
      respData  <= '0;
      initIdx   <= '0;
      lineValid <= '0;
    end else begin
      state     <= next_state;
      held      <= next_held;
      heldRoute <= next_heldRoute;
      heldPfn   <= next_heldPfn;
      busReq    <= next_busReq;
      reqReady  <= next_reqReady;
      respValid <= next_respValid;
      respData  <= next_respData;
      initIdx   <= next_initIdx;
      lineValid <= next_lineValid;
    end
  end

  // Storage arrays, no reset needed: valid bits guard them
  always_ff @(posedge clock) begin
    if (wrLine) begin
      cacheData[wrIdx] <= wrData;
      cacheTag[wrIdx]  <= wrTag;
      cacheWord[wrIdx] <= wrWord;
    end
  end

endmodule
`default_nettype wire

// ===== lscb_path_sva.sv
// Checker: handshake and bus properties of the load/store path
`timescale 1ns/1ps
`default_nettype none
module lscb_path_sva
  import lscb_pkg::*;
#(
  parameter bit HAS_CACHE = 1'b1
) (
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic                        mmuPresent,
  input wire lscb_pkg::lscb_req_type      req,
  input wire logic [lscb_pkg::PFN_W-1:0]  physPfn,
  input wire logic                        pageCacheable,
  input wire logic                        reqReady,
  input wire logic                        respValid,
  input wire logic [lscb_pkg::DATA_W-1:0] respData,
  input wire lscb_pkg::lscb_bus_type      busReq,
  input wire logic                        busWaitreq,
  input wire logic                        busRvalid,
  input wire logic [lscb_pkg::DATA_W-1:0] busRdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ***************
  // Sequences and properties
  // ***************
  sequence s_mgmtTake;
    req.valid && reqReady && (req.cacheInit || req.cacheFlush);
  endsequence
  sequence s_ioTake;
    req.valid && reqReady && req.ioForm && !req.cacheInit && !req.cacheFlush;
  endsequence
  sequence s_writeAccept;
    busReq.valid && busReq.write && !busWaitreq;
  endsequence
  property p_ioToBus;
    s_ioTake |=> busReq.valid && !reqReady;
  endproperty
  a_ioToBus: assert property (p_ioToBus) else $error("io form did not reach bus");
  property p_noTopBit;
    busReq.valid && !mmuPresent |-> !busReq.addr[BYPASS_BIT];
  endproperty
  a_noTopBit: assert property (p_noTopBit) else $error("top address bit on bus");
  property p_wordAligned;
    busReq.valid |-> busReq.addr[1:0] == 2'h0;
  endproperty
  a_wordAligned: assert property (p_wordAligned) else $error("unaligned bus address");
  property p_holdStalled;
    busReq.valid && busWaitreq |=> busReq.valid && $stable(busReq);
  endproperty
  a_holdStalled: assert property (p_holdStalled) else $error("bus cycle dropped");
  property p_writeDone;
    s_writeAccept |=> respValid && reqReady;
  endproperty
  a_writeDone: assert property (p_writeDone) else $error("write not completed");
  property p_readDone;
    busRvalid && !reqReady |=> respValid && reqReady;
  endproperty
  a_readDone: assert property (p_readDone) else $error("read not completed");
  property p_lanes;
    s_writeAccept |-> busReq.byteEn inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  endproperty
  a_lanes: assert property (p_lanes) else $error("illegal byte lanes");
  property p_mgmtNoop;
    s_mgmtTake and (!HAS_CACHE) |=> respValid && !busReq.valid;
  endproperty
  a_mgmtNoop: assert property (p_mgmtNoop) else $error("cache op not a no-op");
  property p_mgmtBusy;
    s_mgmtTake and HAS_CACHE |=> !reqReady && !busReq.valid;
  endproperty
  a_mgmtBusy: assert property (p_mgmtBusy) else $error("cache op not running");
endmodule
bind lscb_path lscb_path_sva #(.HAS_CACHE(HAS_CACHE)) i_sva (.clock(clock), .resetn(resetn),
  .mmuPresent(mmuPresent), .req(req), .physPfn(physPfn), .pageCacheable(pageCacheable),
  .reqReady(reqReady), .respValid(respValid), .respData(respData), .busReq(busReq),
  .busWaitreq(busWaitreq), .busRvalid(busRvalid), .busRdata(busRdata));
`default_nettype wire

// ===== lscb_mem_model.sv
// Partner model: data bus memory with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module lscb_mem_model
  import lscb_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic [3:0]             stall,
  input  wire lscb_pkg::lscb_bus_type busReq,
  output logic                        busWaitreq,
  output logic                        busRvalid,
  output logic [lscb_pkg::DATA_W-1:0] busRdata
);
  logic [31:0] mem [logic [29:0]];
  logic [3:0]  waitCnt;
  logic [31:0] word;
  assign busWaitreq = busReq.valid && (waitCnt != 4'h0);
  always @(posedge clock) begin
    busRvalid <= 1'b0;
    busRdata  <= ~busRdata;
    if (!resetn) begin
      waitCnt  <= stall;
      busRdata <= 32'h0;
    end else if (busReq.valid && !busWaitreq) begin
      waitCnt <= stall;
      word = mem.exists(busReq.addr[31:2]) ? mem[busReq.addr[31:2]] : 32'h0;
      if (busReq.write) begin
        for (int i = 0; i < 4; i++) begin
          if (busReq.byteEn[i]) word[8*i +: 8] = busReq.wdata[8*i +: 8];
        end
        mem[busReq.addr[31:2]] = word;
      end else begin
        busRvalid <= 1'b1;
        busRdata  <= word;
      end
    end else if (busReq.valid) begin
      waitCnt <= waitCnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== load_store_cache_bypass_bench.sv
// Testbench: scenarios for the load/store cache bypass path
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module load_store_cache_bypass_bench;
  import lscb_pkg::*;
  logic clock = 0, resetn = 0, mmuPresent = 0, pageCacheable = 0, mValid;
  logic reqReady, respValid, busWaitreq, busRvalid;
  logic [19:0] physPfn = 20'h0;
  logic [3:0] stall = 4'h0, lastBe;
  logic [31:0] respData, busRdata, rd, lastAddr, prevAddr, lastData;
  lscb_req_type req = '0, mreq = '0;
  lscb_bus_type busReq, mBus;
  int mismatches = 0, total_checks = 0, busCount = 0, n;
  always #2.5 clock = ~clock;
  lscb_path i_dut (.clock(clock), .resetn(resetn), .mmuPresent(mmuPresent), .req(req),
    .physPfn(physPfn), .pageCacheable(pageCacheable), .reqReady(reqReady),
    .respValid(respValid), .respData(respData), .busReq(busReq), .busWaitreq(busWaitreq),
    .busRvalid(busRvalid), .busRdata(busRdata));
  lscb_path #(.HAS_CACHE(1'b0)) i_nocache (.clock(clock), .resetn(resetn),
    .mmuPresent(mmuPresent), .req(mreq), .physPfn(physPfn), .pageCacheable(pageCacheable),
    .reqReady(), .respValid(mValid), .respData(), .busReq(mBus), .busWaitreq(1'b0),
    .busRvalid(1'b0), .busRdata(32'h0));
  lscb_mem_model i_mem (.clock(clock), .resetn(resetn), .stall(stall), .busReq(busReq),
    .busWaitreq(busWaitreq), .busRvalid(busRvalid), .busRdata(busRdata));
  always @(posedge clock) begin
    if (busReq.valid && !busWaitreq) begin
      prevAddr = lastAddr;
      lastAddr = busReq.addr;
      lastBe = busReq.byteEn;
      lastData = busReq.wdata;
      busCount++;
    end
  end
  // ***************
  // Shared tasks
  // ***************
  task automatic acc(input logic st, io, sg, input lscb_size_type sz, input logic [31:0] a,
                     input logic [31:0] d, input logic [1:0] mg = 2'h0);
    int w;
    lscb_req_type r;
    r = '0;
    {r.cacheFlush, r.cacheInit} = mg;
    r.isStore = st;
    r.ioForm = io;
    r.signedLoad = sg;
    r.size = sz;
    r.base = a + 32'h4;
    r.imm = 16'hFFFC;
    r.storeData = d;
    r.valid = 1'b1;
    @(posedge clock);
    #1 req = r;
    @(posedge clock);
    #1 req.valid = 1'b0;
    w = 0;
    while (respValid !== 1'b1 && w < 6000) begin
      @(posedge clock);
      #1 w++;
    end
    `CHECK(w < 6000, 1'b1)
    rd = respData;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ***************
  // Scenarios
  // ***************
  task automatic t_word();
    stall = 4'h3;
    acc(1, 1, 0, LSCB_SZ_WORD, 32'h100, 32'hCAFE1234); // Peripheral via io form
    `CHECK(lastAddr, 32'h100)
    `CHECK({lastBe, lastData}, {4'hF, 32'hCAFE1234})
    acc(1, 1, 0, LSCB_SZ_WORD, 32'h104, 32'h55);
    acc(0, 1, 0, LSCB_SZ_WORD, 32'h100, 32'h0);
    `CHECK({prevAddr, lastAddr}, {32'h104, 32'h100})
    `CHECK(rd, 32'hCAFE1234)
    stall = 4'h0;
  endtask
  task automatic t_bit31();
    n = busCount;
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000100, 32'h0);
    `CHECK(lastAddr, 32'h100)
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000100, 32'h0);
    `CHECK(rd, 32'hCAFE1234)
    `CHECK(busCount, n + 2)
  endtask
  task automatic t_hit();
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
    n = busCount;
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
    `CHECK(busCount, n)
    acc(1, 0, 0, LSCB_SZ_BYTE, 32'h201, 32'h77);
    `CHECK({lastBe, lastData[15:8]}, {4'h2, 8'h77})
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
    `CHECK(rd, 32'h00007700)
    n = busCount;
    acc(0, 1, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
    `CHECK(busCount, n + 1)
  endtask
  task automatic t_mmu();
    mmuPresent = 1'b1;
    pageCacheable = 1'b1;
    physPfn = 20'h80000; // Same color as virtual 0x80000300; the later frame 20'h80001 differs
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000300, 32'h0);
    `CHECK(lastAddr, 32'h80000300)
    n = busCount;
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000300, 32'h0);
    `CHECK(busCount, n)
    physPfn = 20'h80001;
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000300, 32'h0);
    `CHECK(busCount, n + 1)
    pageCacheable = 1'b0;
    acc(0, 0, 0, LSCB_SZ_WORD, 32'h80000300, 32'h0);
    `CHECK(busCount, n + 2)
    mmuPresent = 1'b0;
    physPfn = 20'h0;
  endtask
  task automatic t_narrow();
    acc(1, 1, 0, LSCB_SZ_BYTE, 32'h401, 32'hA5);
    `CHECK({lastBe, lastData[15:8]}, {4'h2, 8'hA5})
    acc(1, 1, 0, LSCB_SZ_HALF, 32'h406, 32'h8001);
    `CHECK({lastBe, lastData[31:16]}, {4'hC, 16'h8001})
    acc(0, 1, 1, LSCB_SZ_BYTE, 32'h401, 32'h0);
    `CHECK(rd, 32'hFFFFFFA5)
    acc(0, 1, 0, LSCB_SZ_BYTE, 32'h401, 32'h0);
    `CHECK(rd, 32'h000000A5)
    acc(0, 0, 1, LSCB_SZ_HALF, 32'h406, 32'h0);
    `CHECK(rd, 32'hFFFF8001)
    acc(0, 0, 0, LSCB_SZ_HALF, 32'h406, 32'h0);
    `CHECK(rd, 32'h00008001)
  endtask
  task automatic t_mgmt();
    for (int k = 1; k < 3; k++) begin
      acc(0, 0, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
      n = busCount;
      acc(0, 0, 0, LSCB_SZ_WORD, 32'h0, 32'h0, k[1:0]);
      `CHECK(busCount, n)
      acc(0, 0, 0, LSCB_SZ_WORD, 32'h200, 32'h0);
      `CHECK(busCount, n + 1)
    end
  endtask
  task automatic t_nocache();
    lscb_req_type m;
    for (int k = 1; k < 3; k++) begin
      m = '0;
      {m.cacheFlush, m.cacheInit} = k[1:0];
      m.valid = 1'b1;
      @(posedge clock);
      #1 mreq = m;
      @(posedge clock);
      #1 mreq.valid = 1'b0;
      `CHECK({mValid, mBus.valid}, 2'b10)
    end
  endtask
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 resetn = 1'b1;
    t_word();
    t_bit31();
    t_hit();
    t_mmu();
    t_narrow();
    t_mgmt();
    t_nocache();
    summarize();
  end
endmodule
`default_nettype wire
